// ### prt_pkg.sv
// Purpose: Shared constants and types of the relay test functions block
// Assumes: 40 MHz mclk, 32-bit register port with byte addresses
// Notes: Register offsets are word aligned

package prt_pkg;

   // Clock and timing
   localparam int unsigned PRT_CLK_HZ = 40000000;
   localparam int unsigned PRT_LAMP_TIME_MS = 2000;
   localparam int unsigned PRT_HEALTHY_TIME_MS = 200;
   localparam int unsigned PRT_LAMP_CYCLES = PRT_LAMP_TIME_MS * (PRT_CLK_HZ / 1000);
   localparam int unsigned PRT_HEALTHY_CYCLES = PRT_HEALTHY_TIME_MS * (PRT_CLK_HZ / 1000);

   // Sizes
   localparam int unsigned PRT_N_LINES = 32;
   localparam int unsigned PRT_N_CONTACTS = 15;
   localparam int unsigned PRT_IN_W = 16;
   localparam int unsigned PRT_OUT_W = 16;

   // Register offsets
   localparam logic [7:0] PRT_ADDR_CTRL = 8'h00;
   localparam logic [7:0] PRT_ADDR_RELAY = 8'h04;
   localparam logic [7:0] PRT_ADDR_RELAY_RST = 8'h08;
   localparam logic [7:0] PRT_ADDR_G1_IN = 8'h0C;
   localparam logic [7:0] PRT_ADDR_G1_OUT = 8'h10;
   localparam logic [7:0] PRT_ADDR_G1_CHK = 8'h14;
   localparam logic [7:0] PRT_ADDR_G2_IN = 8'h18;
   localparam logic [7:0] PRT_ADDR_G2_OUT = 8'h1C;
   localparam logic [7:0] PRT_ADDR_G2_CHK = 8'h20;
   localparam logic [7:0] PRT_ADDR_IRQ_STAT = 8'h24;
   localparam logic [7:0] PRT_ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] PRT_GRP_STRIDE = 8'h0C;

   // CTRL fields
   localparam int unsigned PRT_CTRL_LAMP = 0;
   localparam int unsigned PRT_CTRL_INHIBIT = 1;
   localparam int unsigned PRT_CTRL_ALT_EN = 2;

   // CHK fields
   localparam int unsigned PRT_CHK_LINE_LSB = 0;
   localparam int unsigned PRT_CHK_ERR = 5;
   localparam int unsigned PRT_CHK_BUSY = 31;

   // Interrupt status fields
   localparam int unsigned PRT_IRQ_LAMP_DONE = 0;
   localparam int unsigned PRT_IRQ_G1_DONE = 1;
   localparam int unsigned PRT_IRQ_G2_DONE = 2;
   localparam int unsigned PRT_IRQ_REFUSED = 3;
   localparam int unsigned PRT_IRQ_W = 4;

   // Reset values
   localparam logic [31:0] PRT_CTRL_RST = 32'h0000_0000;
   localparam logic [PRT_IRQ_W-1:0] PRT_MASK_RST = 4'h0;

   typedef enum logic [1:0] {
      PRT_ST_IDLE = 2'b00,
      PRT_ST_SCAN = 2'b01,
      PRT_ST_DONE = 2'b11
   } prt_state_type;

   typedef struct packed {
      logic trip;
      logic alarm;
      logic oos;
      logic healthy;
   } prt_led_type;

   typedef struct packed {
      logic err;
      logic [4:0] line;
   } prt_chk_type;

endpackage : prt_pkg

// ### prt_test_functions.sv
// Purpose: Relay test facilities: lamp test, contact test, scheme check and scheme test
// Assumes: All inputs synchronous to mclk; setting store answers a lookup in the same cycle
// Notes: Summary of operation below
// Summary of operation
// - Lamp test inverts trip, alarm and out-of-service LEDs for about two seconds.
// - During lamp test the healthy LED stays lit briefly, then goes off.
// - After lamp test LEDs show normal state and lamp control returns off itself.
// - Contact test pattern writes accepted only while scheme output is inhibited.
// - While inhibited, each contact except contact 0 follows its test pattern bit.
// - Reset command on contact test clears the whole test pattern.
// - Re-enabling the scheme output clears the whole test pattern.
// - Setting lowest test bit inverts the normally energised inoperative alarm output.
// - Contact status shows scheme logic result, never the test pattern.
// - A line is partly programmed if only AND or only OR matrix has bits.
// - Check scans lines 0 to 31 and reports first partly programmed line.
// - No partly programmed line found gives an OK result.
// - Test input passes through selected group scheme logic to the test output.
// - Scheme test never disturbs live protection operation.
// - Group 2 check and test behave as group 1 on group 2 settings.
// - With alternative group disabled, group 2 controls hidden and group tag dropped.
// - Test controls are excluded from the remote bulk setting transfer.

`timescale 1ns/1ps

module prt_test_functions
   import prt_pkg::*;
#(
   parameter int unsigned LAMP_CYCLES = PRT_LAMP_CYCLES,
   parameter int unsigned HEALTHY_CYCLES = PRT_HEALTHY_CYCLES,
   parameter int unsigned N_CONTACTS = PRT_N_CONTACTS,
   parameter int unsigned IN_W = PRT_IN_W,
   parameter int unsigned OUT_W = PRT_OUT_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic bulk_xfer,
   // Front panel LEDs
   input wire prt_led_type led_norm,
   output prt_led_type led_drv,
   // Output contacts
   input wire logic [N_CONTACTS-1:0] scheme_out,
   output logic [N_CONTACTS-1:0] contact_drv,
   output logic [N_CONTACTS-1:0] contact_status,
   output logic scheme_inhibit,
   // Scheme setting lookup
   output logic set_grp,
   output logic [4:0] set_line,
   input wire logic [IN_W-1:0] set_and,
   input wire logic [OUT_W-1:0] set_or,
   input wire logic settings_changed,
   // Menu presentation and interrupt
   output logic group_tag_on,
   output logic irq
);

   localparam int unsigned LAMP_W = $clog2(LAMP_CYCLES + 1);

   initial begin
      if (N_CONTACTS < 1 || N_CONTACTS > 32 || IN_W < 1 || IN_W > 32 || OUT_W < 1 || OUT_W > 32)
         $error("prt_test_functions: widths must be 1 to 32");
      if (HEALTHY_CYCLES < 1 || HEALTHY_CYCLES >= LAMP_CYCLES)
         $error("prt_test_functions: healthy time must be shorter than lamp time");
   end

   // True when addr hits the group register at base offset for group g
   function automatic logic grp_hit(input logic [7:0] addr, input logic [7:0] base, input logic g);
      logic [7:0] off;
      off = g ? 8'(base + PRT_GRP_STRIDE) : base;
      grp_hit = (addr == off);
   endfunction : grp_hit

   // Control register
   logic inhibit_ff;
   logic alt_en_ff;
   logic wr_ok;

   // Test controls never take part in a bulk transfer
   assign wr_ok = reg_wr && !bulk_xfer;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         inhibit_ff <= PRT_CTRL_RST[PRT_CTRL_INHIBIT];
         alt_en_ff <= PRT_CTRL_RST[PRT_CTRL_ALT_EN];
      end else if (wr_ok && reg_addr == PRT_ADDR_CTRL) begin
         inhibit_ff <= reg_wdata[PRT_CTRL_INHIBIT];
         alt_en_ff <= reg_wdata[PRT_CTRL_ALT_EN];
      end
   end

   assign scheme_inhibit = inhibit_ff;
   assign group_tag_on = alt_en_ff;

   // Lamp test timer
   logic lamp_on_ff;
   logic [LAMP_W-1:0] lamp_cnt_ff;
   logic lamp_start;
   logic lamp_end;

   assign lamp_start = wr_ok && reg_addr == PRT_ADDR_CTRL && reg_wdata[PRT_CTRL_LAMP] && !lamp_on_ff;
   assign lamp_end = lamp_on_ff && lamp_cnt_ff == LAMP_W'(LAMP_CYCLES - 1);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lamp_on_ff <= 1'b0;
         lamp_cnt_ff <= '0;
      end else if (lamp_start) begin
         lamp_on_ff <= 1'b1;
         lamp_cnt_ff <= '0;
      end else if (lamp_end) begin
         lamp_on_ff <= 1'b0;
         lamp_cnt_ff <= '0;
      end else if (lamp_on_ff) begin
         lamp_cnt_ff <= lamp_cnt_ff + 1'b1;
      end
   end

   prt_led_type nxt_led;
   prt_led_type led_ff;

   always_comb begin
      nxt_led = led_norm;
      if (lamp_on_ff) begin
         nxt_led.trip = ~led_norm.trip;
         nxt_led.alarm = ~led_norm.alarm;
         nxt_led.oos = ~led_norm.oos;
         nxt_led.healthy = lamp_cnt_ff < LAMP_W'(HEALTHY_CYCLES);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         led_ff <= '0;
      else
         led_ff <= nxt_led;
   end

   assign led_drv = led_ff;

   // Output contact test pattern
   logic [N_CONTACTS-1:0] pattern_ff;
   logic relay_wr;
   logic relay_refused;

   assign relay_wr = wr_ok && reg_addr == PRT_ADDR_RELAY;
   assign relay_refused = relay_wr && !inhibit_ff;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pattern_ff <= '0;
      end else if (inhibit_ff && wr_ok && reg_addr == PRT_ADDR_CTRL && !reg_wdata[PRT_CTRL_INHIBIT]) begin
         pattern_ff <= '0;
      end else if (wr_ok && reg_addr == PRT_ADDR_RELAY_RST) begin
         pattern_ff <= '0;
      end else if (relay_wr && inhibit_ff) begin
         pattern_ff <= reg_wdata[N_CONTACTS-1:0];
      end
   end

   logic [N_CONTACTS-1:0] nxt_contact;
   logic [N_CONTACTS-1:0] contact_ff;
   logic [N_CONTACTS-1:0] status_ff;

   always_comb begin
      nxt_contact = scheme_out;
      if (inhibit_ff) begin
         nxt_contact = pattern_ff;
         nxt_contact[0] = ~pattern_ff[0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         contact_ff <= '0;
         status_ff <= '0;
      end else begin
         contact_ff <= nxt_contact;
         status_ff <= scheme_out;
      end
   end

   assign contact_drv = contact_ff;
   assign contact_status = status_ff;

   // Per-group test input registers
   logic [IN_W-1:0] test_in_ff [2];
   logic [1:0] in_wr;

   for (genvar g = 0; g < 2; g++) begin : g_in
      assign in_wr[g] = wr_ok && grp_hit(reg_addr, PRT_ADDR_G1_IN, g[0]) && (g == 0 || alt_en_ff);
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n)
            test_in_ff[g] <= '0;
         else if (in_wr[g])
            test_in_ff[g] <= reg_wdata[IN_W-1:0];
      end
   end

   // Scan engine, shared by both groups; reads settings only
   prt_state_type state_ff;
   logic [1:0] pend_ff;
   logic grp_ff;
   logic [4:0] line_ff;
   logic [IN_W-1:0] cur_in_ff;
   logic [OUT_W-1:0] acc_ff;
   prt_chk_type find_ff;
   logic [OUT_W-1:0] test_out_ff [2];
   prt_chk_type chk_ff [2];
   logic [1:0] busy;
   logic [1:0] start_evt;
   logic line_live;
   logic line_part;

   assign set_grp = grp_ff;
   assign set_line = line_ff;
   assign line_live = (set_and != '0) && ((set_and & cur_in_ff) == set_and);
   assign line_part = (set_and != '0) != (set_or != '0);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         pend_ff <= 2'b11;
      else
         pend_ff <= (pend_ff & ~start_evt) | in_wr | {2{settings_changed}};
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= PRT_ST_IDLE;
         grp_ff <= 1'b0;
         line_ff <= '0;
         cur_in_ff <= '0;
         acc_ff <= '0;
         find_ff <= '0;
      end else begin
         case (state_ff)
            PRT_ST_IDLE: begin
               if (pend_ff != 2'b00) begin
                  grp_ff <= ~pend_ff[0];
                  cur_in_ff <= pend_ff[0] ? test_in_ff[0] : test_in_ff[1];
                  line_ff <= '0;
                  acc_ff <= '0;
                  find_ff <= '0;
                  state_ff <= PRT_ST_SCAN;
               end
            end
            PRT_ST_SCAN: begin
               if (line_live)
                  acc_ff <= acc_ff | set_or;
               if (line_part && !find_ff.err) begin
                  find_ff.err <= 1'b1;
                  find_ff.line <= line_ff;
               end
               if (line_ff == 5'(PRT_N_LINES - 1))
                  state_ff <= PRT_ST_DONE;
               else
                  line_ff <= line_ff + 5'h01;
            end
            PRT_ST_DONE: begin
               state_ff <= PRT_ST_IDLE;
            end
            default: begin
               state_ff <= PRT_ST_IDLE;
            end
         endcase
      end
   end

   // Pend drops as a scan starts, so a write arriving mid-scan reruns it
   for (genvar g = 0; g < 2; g++) begin : g_res
      assign start_evt[g] = state_ff == PRT_ST_IDLE && (g == 0 ? pend_ff[0] : pend_ff[1] && !pend_ff[0]);
      assign busy[g] = pend_ff[g] || (state_ff != PRT_ST_IDLE && grp_ff == g[0]);
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            test_out_ff[g] <= '0;
            chk_ff[g] <= '0;
         end else if (state_ff == PRT_ST_DONE && grp_ff == g[0]) begin
            test_out_ff[g] <= acc_ff;
            chk_ff[g] <= find_ff;
         end
      end
   end

   // Interrupt status and mask
   logic [PRT_IRQ_W-1:0] irq_stat_ff;
   logic [PRT_IRQ_W-1:0] irq_mask_ff;
   logic [PRT_IRQ_W-1:0] irq_set;
   logic stat_rd;

   assign irq_set[PRT_IRQ_LAMP_DONE] = lamp_end;
   assign irq_set[PRT_IRQ_G1_DONE] = state_ff == PRT_ST_DONE && !grp_ff;
   assign irq_set[PRT_IRQ_G2_DONE] = state_ff == PRT_ST_DONE && grp_ff && alt_en_ff;
   assign irq_set[PRT_IRQ_REFUSED] = relay_refused;
   assign stat_rd = reg_rd && reg_addr == PRT_ADDR_IRQ_STAT;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         irq_stat_ff <= '0;
      else if (stat_rd)
         irq_stat_ff <= irq_set;
      else
         irq_stat_ff <= irq_stat_ff | irq_set;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         irq_mask_ff <= PRT_MASK_RST;
      else if (reg_wr && reg_addr == PRT_ADDR_IRQ_MASK)
         irq_mask_ff <= reg_wdata[PRT_IRQ_W-1:0];
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Read data, one cycle after the strobe
   logic [31:0] nxt_rdata;
   logic [31:0] rdata_ff;
   logic rd_g2_ok;

   assign rd_g2_ok = alt_en_ff;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_addr == PRT_ADDR_CTRL) begin
         nxt_rdata[PRT_CTRL_LAMP] = lamp_on_ff;
         nxt_rdata[PRT_CTRL_INHIBIT] = inhibit_ff;
         nxt_rdata[PRT_CTRL_ALT_EN] = alt_en_ff;
      end else if (reg_addr == PRT_ADDR_RELAY) begin
         nxt_rdata[N_CONTACTS-1:0] = pattern_ff;
      end else if (reg_addr == PRT_ADDR_G1_IN) begin
         nxt_rdata[IN_W-1:0] = test_in_ff[0];
      end else if (reg_addr == PRT_ADDR_G1_OUT) begin
         nxt_rdata[OUT_W-1:0] = test_out_ff[0];
      end else if (reg_addr == PRT_ADDR_G1_CHK) begin
         nxt_rdata[PRT_CHK_LINE_LSB +: 5] = chk_ff[0].line;
         nxt_rdata[PRT_CHK_ERR] = chk_ff[0].err;
         nxt_rdata[PRT_CHK_BUSY] = busy[0];
      end else if (rd_g2_ok && grp_hit(reg_addr, PRT_ADDR_G1_IN, 1'b1)) begin
         nxt_rdata[IN_W-1:0] = test_in_ff[1];
      end else if (rd_g2_ok && grp_hit(reg_addr, PRT_ADDR_G1_OUT, 1'b1)) begin
         nxt_rdata[OUT_W-1:0] = test_out_ff[1];
      end else if (rd_g2_ok && grp_hit(reg_addr, PRT_ADDR_G1_CHK, 1'b1)) begin
         nxt_rdata[PRT_CHK_LINE_LSB +: 5] = chk_ff[1].line;
         nxt_rdata[PRT_CHK_ERR] = chk_ff[1].err;
         nxt_rdata[PRT_CHK_BUSY] = busy[1];
      end else if (reg_addr == PRT_ADDR_IRQ_STAT) begin
         nxt_rdata[PRT_IRQ_W-1:0] = irq_stat_ff;
      end else if (reg_addr == PRT_ADDR_IRQ_MASK) begin
         nxt_rdata[PRT_IRQ_W-1:0] = irq_mask_ff;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         rdata_ff <= '0;
      else if (reg_rd)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= '0;
   end

   assign reg_rdata = rdata_ff;

endmodule : prt_test_functions

// ### prt_store.sv
// Purpose: Scheme setting store behind the lookup port
// Assumes: Lookup answered in the same cycle
// Notes: Bench fills entries directly
`timescale 1ns/1ps
module prt_store (
   // Lookup address
   input wire logic set_grp,
   input wire logic [4:0] set_line,
   // Matrix answer
   output logic [15:0] set_and,
   output logic [15:0] set_or
);
   logic [15:0] and_m [0:1][0:31];
   logic [15:0] or_m [0:1][0:31];
   initial begin
      for (int g = 0; g < 2; g++) begin
         for (int l = 0; l < 32; l++) begin
            and_m[g][l] = 16'h0;
            or_m[g][l] = 16'h0;
         end
      end
   end
   assign set_and = and_m[set_grp][set_line];
   assign set_or = or_m[set_grp][set_line];
endmodule : prt_store

// ### prt_test_functions_sva.sv
// Purpose: Port assertions of the relay test functions block
// Assumes: One mclk domain, async active-low reset
// Notes: Lamp window tracked by a helper counter
`timescale 1ns/1ps
module prt_test_functions_sva
   import prt_pkg::*;
#(
   parameter int unsigned LAMP_CYCLES = 100,
   parameter int unsigned HEALTHY_CYCLES = 20,
   parameter int unsigned N_CONTACTS = 15
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic bulk_xfer,
   // Panel and contacts
   input wire prt_led_type led_norm,
   input wire prt_led_type led_drv,
   input wire logic [N_CONTACTS-1:0] scheme_out,
   input wire logic [N_CONTACTS-1:0] contact_drv,
   input wire logic [N_CONTACTS-1:0] contact_status,
   input wire logic scheme_inhibit,
   // Presentation and interrupt
   input wire logic group_tag_on,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   int lamp_cnt_ff;
   logic [3:0] norm_d_ff;
   logic ctrl_wr;
   assign ctrl_wr = reg_wr && reg_addr == PRT_ADDR_CTRL && !bulk_xfer;
   // Cycles since an accepted lamp start, saturating
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lamp_cnt_ff <= 0;
      end else if (ctrl_wr && reg_wdata[0] && (lamp_cnt_ff == 0 || lamp_cnt_ff > LAMP_CYCLES + 4)) begin
         lamp_cnt_ff <= 1;
      end else if (lamp_cnt_ff != 0 && lamp_cnt_ff <= LAMP_CYCLES + 4) begin
         lamp_cnt_ff <= lamp_cnt_ff + 1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         norm_d_ff <= 4'h0;
      end else begin
         norm_d_ff <= led_norm;
      end
   end
   a_status_follows: assert property ($past(rst_n) |-> contact_status == $past(scheme_out))
      else $error("contact status left scheme result");
   a_drive_live: assert property ($past(rst_n) && !scheme_inhibit && !$past(scheme_inhibit)
      |-> contact_drv == $past(scheme_out))
      else $error("contacts not live while enabled");
   a_tag_cause: assert property ($past(rst_n) && $changed(group_tag_on) |-> $past(ctrl_wr))
      else $error("group tag changed without write");
   a_inhibit_cause: assert property ($past(rst_n) && $changed(scheme_inhibit) |-> $past(ctrl_wr))
      else $error("inhibit changed without write");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_grp2_hidden: assert property ($past(reg_rd && !group_tag_on && reg_addr >= PRT_ADDR_G2_IN
      && reg_addr <= PRT_ADDR_G2_CHK) |-> reg_rdata == 32'h0)
      else $error("group 2 visible while disabled");
   a_mask_quiet: assert property ($past(reg_wr && reg_addr == PRT_ADDR_IRQ_MASK && reg_wdata[3:0] == 4'h0)
      |-> ##1 !irq)
      else $error("irq with all masked");
   a_lamp_normal: assert property ($past(rst_n) && (lamp_cnt_ff == 0 || lamp_cnt_ff > LAMP_CYCLES + 4)
      |-> led_drv == norm_d_ff)
      else $error("leds not normal outside lamp test");
   a_lamp_invert: assert property (lamp_cnt_ff inside {[3:LAMP_CYCLES-2]}
      |-> led_drv[3:1] == ~norm_d_ff[3:1])
      else $error("leds not inverted in lamp test");
   a_healthy_on: assert property (lamp_cnt_ff inside {[3:HEALTHY_CYCLES-2]} |-> led_drv.healthy)
      else $error("healthy led off too early");
   a_healthy_off: assert property (lamp_cnt_ff inside {[HEALTHY_CYCLES+4:LAMP_CYCLES-2]}
      |-> !led_drv.healthy)
      else $error("healthy led still on");
   c_lamp: cover property (lamp_cnt_ff == LAMP_CYCLES);
   c_irq: cover property ($rose(irq));
   c_inhibit: cover property ($rose(scheme_inhibit));
   c_grp2: cover property (reg_rd && group_tag_on && reg_addr == PRT_ADDR_G2_CHK);
endmodule : prt_test_functions_sva

// ### prt_test_functions_tb.sv
// Purpose: Self-checking bench of the relay test functions block
// Assumes: Setting store model answers lookups at once
// Notes: Short lamp counts keep the run brief
`timescale 1ns/1ps
module prt_test_functions_tb;
   import prt_pkg::*;
   localparam int unsigned LAMP = 100;
   localparam int unsigned HLT = 20;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} prt_note_type;
   logic mclk, rst_n, reg_wr, reg_rd, bulk_xfer, settings_changed, scheme_inhibit;
   logic set_grp, group_tag_on, irq;
   logic rd_seen = 1'b0;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   prt_led_type led_norm, led_drv;
   logic [14:0] scheme_out, contact_drv, contact_status;
   logic [4:0] set_line;
   logic [15:0] set_and, set_or, pat, tin;
   prt_note_type notes[$];
   int err_count, cmp_count;
   prt_test_functions #(.LAMP_CYCLES(LAMP), .HEALTHY_CYCLES(HLT)) i_prt_test_functions (.*);
   prt_store i_prt_store (.*);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      notes.push_back('{$sformatf("reg %h", a), e, m});
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic kick;
      @(posedge mclk);
      settings_changed <= 1'b1;
      @(posedge mclk);
      settings_changed <= 1'b0;
      idle(100);
   endtask : kick
   task automatic put(input int g, input int l, input logic [15:0] a, input logic [15:0] o);
      i_prt_store.and_m[g][l] = a;
      i_prt_store.or_m[g][l] = o;
   endtask : put
   function automatic logic [15:0] model_out(input int g, input logic [15:0] in);
      logic [15:0] r;
      r = 16'h0;
      for (int l = 0; l < 32; l++) begin
         if (i_prt_store.and_m[g][l] != 16'h0 && (i_prt_store.and_m[g][l] & ~in) == 16'h0) begin
            r |= i_prt_store.or_m[g][l];
         end
      end
      return r;
   endfunction : model_out
   // Read results noted by the driver, compared in order
   always @(posedge mclk) begin
      if (rd_seen) begin
         check(notes[0].nm, reg_rdata & notes[0].msk, notes[0].exp);
         void'(notes.pop_front());
      end
      rd_seen = reg_rd;
   end
   initial begin
      idle(5000);
      err_count++;
      stop_test;
   end
   initial begin
      void'($urandom(80));
      {rst_n, reg_wr, reg_rd, bulk_xfer, settings_changed} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      led_norm = 4'h1;
      scheme_out = 15'h0;
      idle(3);
      rst_n <= 1'b1;
      idle(100);
      rd(PRT_ADDR_CTRL, 32'h0, ALL);
      rd(PRT_ADDR_IRQ_MASK, 32'h0, ALL);
      rd(8'h2C, 32'h0, ALL);
      rd(PRT_ADDR_G2_IN, 32'h0, ALL);
      rd(PRT_ADDR_G1_CHK, 32'h0, ALL);
      rd(PRT_ADDR_IRQ_STAT, 32'h2, 32'hB);
      rd(PRT_ADDR_IRQ_STAT, 32'h0, 32'hB);
      scheme_out <= 15'($urandom);
      pat = 16'($urandom) | 16'h1;
      wr(PRT_ADDR_RELAY, {17'h0, pat[14:0]});
      rd(PRT_ADDR_RELAY, 32'h0, ALL);
      rd(PRT_ADDR_IRQ_STAT, 32'h8, 32'h8);
      wr(PRT_ADDR_CTRL, 32'h2);
      #1;
      check("inhibit", {31'h0, scheme_inhibit}, 32'h1);
      wr(PRT_ADDR_RELAY, {17'h0, pat[14:0]});
      rd(PRT_ADDR_RELAY, {17'h0, pat[14:0]}, ALL);
      #1;
      check("contact drive", {17'h0, contact_drv}, {17'h0, pat[14:0] ^ 15'h1});
      check("contact status", {17'h0, contact_status}, {17'h0, scheme_out});
      wr(PRT_ADDR_RELAY_RST, 32'h1);
      rd(PRT_ADDR_RELAY, 32'h0, ALL);
      #1;
      check("contact reset", {17'h0, contact_drv}, 32'h1);
      wr(PRT_ADDR_RELAY, {17'h0, pat[14:0]});
      wr(PRT_ADDR_CTRL, 32'h0);
      rd(PRT_ADDR_RELAY, 32'h0, ALL);
      bulk_xfer <= 1'b1;
      wr(PRT_ADDR_CTRL, 32'h4);
      wr(PRT_ADDR_IRQ_MASK, 32'h2);
      bulk_xfer <= 1'b0;
      rd(PRT_ADDR_CTRL, 32'h0, ALL);
      rd(PRT_ADDR_IRQ_MASK, 32'h2, ALL);
      put(0, 3, 16'h0003, 16'h0010);
      put(0, 5, 16'h0004, 16'h0100);
      put(0, 7, 16'h0000, 16'h0020);
      put(0, 9, 16'h0800, 16'h0000);
      put(1, 0, 16'h8000, 16'h4000);
      put(1, 31, 16'h0000, 16'h0001);
      kick;
      #1;
      check("irq raised", {31'h0, irq}, 32'h1);
      rd(PRT_ADDR_G1_CHK, 32'h27, 32'h8000003F);
      rd(PRT_ADDR_IRQ_STAT, 32'h2, 32'h2);
      #1;
      check("irq cleared", {31'h0, irq}, 32'h0);
      wr(PRT_ADDR_IRQ_MASK, 32'h0);
      for (int i = 0; i < 4; i++) begin
         tin = (i == 0) ? 16'h0007 : 16'($urandom);
         if (i == 1) begin
            wr(PRT_ADDR_G1_IN, {16'h0, ~tin});
            idle(10);
         end
         wr(PRT_ADDR_G1_IN, {16'h0, tin});
         idle(80);
         rd(PRT_ADDR_G1_OUT, {16'h0, model_out(0, tin)}, 32'hFFFF);
      end
      wr(PRT_ADDR_CTRL, 32'h4);
      #1;
      check("group tag", {31'h0, group_tag_on}, 32'h1);
      kick;
      rd(PRT_ADDR_G2_CHK, 32'h3F, 32'h8000003F);
      wr(PRT_ADDR_G2_IN, 32'h8000);
      idle(40);
      rd(PRT_ADDR_G2_OUT, 32'h4000, 32'hFFFF);
      #1;
      check("contacts live", {17'h0, contact_drv}, {17'h0, scheme_out});
      @(posedge mclk);
      led_norm <= prt_led_type'({3'($urandom), 1'b1});
      wr(PRT_ADDR_CTRL, 32'h5);
      idle(8);
      #1;
      check("lamp on", {28'h0, led_drv}, {28'h0, ~led_norm[3:1], 1'b1});
      idle(50);
      #1;
      check("lamp healthy", {28'h0, led_drv}, {28'h0, ~led_norm[3:1], 1'b0});
      rd(PRT_ADDR_CTRL, 32'h1, 32'h1);
      idle(60);
      #1;
      check("lamp end", {28'h0, led_drv}, {28'h0, led_norm});
      rd(PRT_ADDR_CTRL, 32'h4, ALL);
      rd(PRT_ADDR_IRQ_STAT, 32'h1, 32'h1);
      idle(2);
      stop_test;
   end
endmodule : prt_test_functions_tb
bind prt_test_functions prt_test_functions_sva #(.LAMP_CYCLES(LAMP_CYCLES), .HEALTHY_CYCLES(HEALTHY_CYCLES),
   .N_CONTACTS(N_CONTACTS)) i_prt_test_functions_sva (.*);
